// file: design/rrx_pkg.sv
`default_nettype none
package rrx_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 2;
  // register map
  localparam logic [ADDR_W-1:0] OFS_IC [NUM_CH] = '{12'h071, 12'h072};
  localparam logic [ADDR_W-1:0] OFS_SEL = 12'h206;
  localparam logic [ADDR_W-1:0] OFS_CH_BASE [NUM_CH] = '{12'h100, 12'h120};
  localparam int CH_IDX_W = 5;
  localparam logic [CH_IDX_W-1:0] R_CON0 = 5'h00;
  localparam logic [CH_IDX_W-1:0] R_CON2 = 5'h02;
  localparam logic [CH_IDX_W-1:0] R_INT = 5'h03;
  localparam logic [CH_IDX_W-1:0] R_HDMIN = 5'h04;
  localparam logic [CH_IDX_W-1:0] R_HDMAX = 5'h05;
  localparam logic [CH_IDX_W-1:0] R_D0MIN = 5'h06;
  localparam logic [CH_IDX_W-1:0] R_D0MAX = 5'h07;
  localparam logic [CH_IDX_W-1:0] R_D1MIN = 5'h08;
  localparam logic [CH_IDX_W-1:0] R_D1MAX = 5'h09;
  localparam logic [CH_IDX_W-1:0] R_CPC = 5'h0A;
  localparam logic [CH_IDX_W-1:0] R_CPD = 5'h0B;
  // field layout
  localparam int IC_LVL_W = 3;
  localparam int IC_IR_BIT = 3;
  localparam int SEL_W = 8;
  localparam int SEL_BIT [NUM_CH] = '{4, 5};
  localparam int CON0_EN = 0;
  localparam int CON0_HDR = 1;
  localparam int CON0_SPEC = 2;
  localparam int CON0_PAT = 3;
  localparam int CON2_RUN = 0;
  localparam int CON2_OVF = 1;
  localparam int CON2_OVF_EN = 2;
  localparam int INT_W = 8;
  localparam int HD_W = 11;
  localparam int DW_W = 8;
  localparam int CPN_W = 3;
  localparam int CPC_EN = 3;
  localparam int CNT_W = 16;
  localparam int BIT_CNT_W = 6;
  localparam logic [BIT_CNT_W-1:0] BUF_FULL_COUNT = 6'h30;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  // event index; ovf sits above the eight enable-register sources
  localparam int EV_CMP = 0;
  localparam int EV_ERR = 1;
  localparam int EV_DONE = 2;
  localparam int EV_BFUL = 3;
  localparam int EV_HDR = 4;
  localparam int EV_DATA = 5;
  localparam int EV_MEAS = 6;
  localparam int EV_SPEC = 7;
  localparam int EV_OVF = 8;
  localparam int NUM_EV = 9;

  typedef enum logic [1:0] {
    RUN_STOP = 2'b00,
    RUN_ARM = 2'b01,
    RUN_GO = 2'b11
  } rrx_run_st_t;

  typedef struct packed {
    logic pattern;
    logic header_required;
    logic special_en;
    logic cmp_en;
    logic [CPN_W-1:0] compare_bit_count_select;
    logic [HD_W-1:0] hd_min;
    logic [HD_W-1:0] hd_max;
    logic [DW_W-1:0] d0_min;
    logic [DW_W-1:0] d0_max;
    logic [DW_W-1:0] d1_min;
    logic [DW_W-1:0] d1_max;
    logic [DW_W-1:0] cmp_data;
  } rrx_ch_cfg_t;

  function automatic logic rrx_in_win(input logic [CNT_W-1:0] v,
                                      input logic [CNT_W-1:0] lo,
                                      input logic [CNT_W-1:0] hi);
    rrx_in_win = (v >= lo) && (v <= hi);
  endfunction : rrx_in_win

  function automatic logic rrx_ch_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] base);
    rrx_ch_hit = a[ADDR_W-1:CH_IDX_W] == base[ADDR_W-1:CH_IDX_W];
  endfunction : rrx_ch_hit
endpackage : rrx_pkg
`default_nettype wire

// file: design/rrx_evt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rrx_evt_if;
  import rrx_pkg::*;
  rrx_ch_cfg_t cfg;
  logic running;
  logic measure_end;
  logic [CNT_W-1:0] meas_value;
  logic [CNT_W-1:0] counter;
  logic [BIT_CNT_W-1:0] bit_count;
  logic [DW_W-1:0] rx_data0;
  logic [NUM_EV-1:0] events;
  logic ovf_flag;
  modport ctl (output cfg, running, measure_end, meas_value, counter,
    bit_count, rx_data0, input events, ovf_flag);
  modport evt (input cfg, running, measure_end, meas_value, counter,
    bit_count, rx_data0, output events, ovf_flag);
endinterface : rrx_evt_if
`default_nettype wire

// file: design/rrx_run_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module rrx_run_ctl
  import rrx_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire logic count_tick,
  output logic running
);
  typedef struct packed {
    rrx_run_st_t st;
  } rrx_run_state_t;
  rrx_run_state_t state_reg;
  rrx_run_state_t state_next;

  // start needs two count-source ticks, stop only one
  always_comb
  begin
    state_next = state_reg;
    if (count_tick)
    begin
      case (state_reg.st)
        RUN_STOP: state_next.st = enable ? RUN_ARM : RUN_STOP;
        RUN_ARM: state_next.st = enable ? RUN_GO : RUN_STOP;
        RUN_GO: state_next.st = enable ? RUN_GO : RUN_STOP;
        default: state_next.st = RUN_STOP;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_reg <= '{st: RUN_STOP};
    else
      state_reg <= state_next;
  end

  assign running = state_reg.st == RUN_GO;
endmodule : rrx_run_ctl
`default_nettype wire

// file: design/rrx_chan_evt.sv
`timescale 1ns/1ns
`default_nettype none
module rrx_chan_evt
  import rrx_pkg::*;
#(
  parameter bit HAS_EXT = 1'b1
)
(
  input wire logic clock,
  input wire logic reset,
  rrx_evt_if.evt ev_if
);
  typedef struct packed {
    logic [CNT_W-1:0] prev_cnt;
    logic done_cond;
    logic bful_cond;
    logic cmp_cond;
    logic header_seen;
    logic ovf_flag;
    logic [NUM_EV-1:0] events;
  } rrx_evt_state_t;
  rrx_evt_state_t state_reg;
  rrx_evt_state_t state_next;

  always_comb
  begin
    logic run, pat, mend, hd, d0, d1, wrap;
    logic done_now, bful_now, cmp_now;
    logic [DW_W-1:0] mask;
    run = 1'b0;
    pat = 1'b0;
    mend = 1'b0;
    hd = 1'b0;
    d0 = 1'b0;
    d1 = 1'b0;
    wrap = 1'b0;
    done_now = 1'b0;
    bful_now = 1'b0;
    cmp_now = 1'b0;
    mask = '0;
    state_next = state_reg;
    run = ev_if.running;
    pat = ev_if.cfg.pattern;
    mend = run && ev_if.measure_end;
    hd = rrx_in_win(ev_if.meas_value, CNT_W'(ev_if.cfg.hd_min),
      CNT_W'(ev_if.cfg.hd_max));
    d0 = rrx_in_win(ev_if.meas_value, CNT_W'(ev_if.cfg.d0_min),
      CNT_W'(ev_if.cfg.d0_max));
    d1 = rrx_in_win(ev_if.meas_value, CNT_W'(ev_if.cfg.d1_min),
      CNT_W'(ev_if.cfg.d1_max));
    done_now = run && pat && (ev_if.counter > CNT_W'(ev_if.cfg.hd_max))
      && (ev_if.counter > CNT_W'(ev_if.cfg.d0_max))
      && (ev_if.counter > CNT_W'(ev_if.cfg.d1_max));
    bful_now = HAS_EXT && run && pat
      && (ev_if.bit_count == BUF_FULL_COUNT);
    mask = 8'hFF >> (3'h7 - ev_if.cfg.compare_bit_count_select);
    cmp_now = HAS_EXT && run && pat && ev_if.cfg.cmp_en
      && (((ev_if.cfg.cmp_data ^ ev_if.rx_data0) & mask) == '0);
    wrap = run && !pat && (state_reg.prev_cnt == CNT_MAX)
      && (ev_if.counter == CNT_ZERO);
    state_next.prev_cnt = ev_if.counter;
    state_next.done_cond = done_now;
    state_next.bful_cond = bful_now;
    state_next.cmp_cond = cmp_now;
    state_next.events = '0;
    // level conditions fire once, on entry
    state_next.events[EV_DONE] = done_now && !state_reg.done_cond;
    state_next.events[EV_BFUL] = bful_now && !state_reg.bful_cond;
    state_next.events[EV_CMP] = cmp_now && !state_reg.cmp_cond;
    state_next.events[EV_HDR] = mend && pat && ev_if.cfg.header_required
      && hd;
    state_next.events[EV_DATA] = mend && pat && (d0 || d1);
    state_next.events[EV_SPEC] = HAS_EXT && mend && pat
      && ev_if.cfg.special_en && hd;
    state_next.events[EV_ERR] = mend && pat && (!(hd || d0 || d1)
      || ((d0 || d1) && ev_if.cfg.header_required
      && !state_reg.header_seen));
    state_next.events[EV_MEAS] = mend;
    state_next.events[EV_OVF] = wrap;
    if (done_now || !run)
      state_next.header_seen = 1'b0;
    if (mend && pat && hd)
      state_next.header_seen = 1'b1;
    // flag held until the next measurement; a wrap then still wins
    if (mend)
      state_next.ovf_flag = 1'b0;
    if (wrap)
      state_next.ovf_flag = 1'b1;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign ev_if.events = state_reg.events;
  assign ev_if.ovf_flag = state_reg.ovf_flag;
endmodule : rrx_chan_evt
`default_nettype wire

// file: design/rrx_top.sv
`timescale 1ns/1ns
`default_nettype none
module rrx_top
  import rrx_pkg::*;
#(
  parameter int CHANNELS = rrx_pkg::NUM_CH
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [rrx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rrx_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [rrx_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [rrx_pkg::NUM_CH-1:0] count_tick,
  input wire logic [rrx_pkg::NUM_CH-1:0] measure_end,
  input wire logic [rrx_pkg::CNT_W-1:0] measured_value0,
  input wire logic [rrx_pkg::CNT_W-1:0] measured_value1,
  input wire logic [rrx_pkg::CNT_W-1:0] running_counter0,
  input wire logic [rrx_pkg::CNT_W-1:0] running_counter1,
  input wire logic [rrx_pkg::BIT_CNT_W-1:0] received_bit_count,
  input wire logic [rrx_pkg::DW_W-1:0] first_receive_data,
  output logic [rrx_pkg::NUM_CH-1:0] channel_enable,
  output logic [rrx_pkg::NUM_CH-1:0] running_flag,
  output logic [rrx_pkg::NUM_CH-1:0] irq_request
);
  if (CHANNELS != NUM_CH)
  begin : g_bad_channels
    $error("rrx_top serves exactly two channels");
  end

  typedef struct packed {
    logic [NUM_CH-1:0][IC_LVL_W-1:0] lvl;
    logic [NUM_CH-1:0] pending;
    logic [SEL_W-1:0] sel;
    logic [NUM_CH-1:0] en;
    logic [NUM_CH-1:0] ovf_en;
    logic [NUM_CH-1:0][INT_W-1:0] int_en;
    rrx_ch_cfg_t [NUM_CH-1:0] cfg;
    logic [DATA_W-1:0] rdata;
    logic [NUM_CH-1:0] irq;
    logic [NUM_CH-1:0] run;
  } rrx_top_state_t;
  rrx_top_state_t state_reg;
  rrx_top_state_t state_next;

  logic [NUM_CH-1:0] running;
  logic [NUM_CH-1:0][NUM_EV-1:0] events;
  logic [NUM_CH-1:0] ovf_flag;
  logic [NUM_CH-1:0][CNT_W-1:0] meas_values;
  logic [NUM_CH-1:0][CNT_W-1:0] counters;

  assign meas_values = {measured_value1, measured_value0};
  assign counters = {running_counter1, running_counter0};

  rrx_evt_if evt_if [NUM_CH] ();

  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    assign evt_if[g].cfg = state_reg.cfg[g];
    assign evt_if[g].running = running[g];
    assign evt_if[g].measure_end = measure_end[g];
    assign evt_if[g].meas_value = meas_values[g];
    assign evt_if[g].counter = counters[g];
    assign evt_if[g].bit_count = received_bit_count;
    assign evt_if[g].rx_data0 = first_receive_data;
    assign events[g] = evt_if[g].events;
    assign ovf_flag[g] = evt_if[g].ovf_flag;

    // one source unit per channel, its own request path
    rrx_chan_evt #(
      .HAS_EXT(g == 0)
    ) u_evt (
      .clock(clock),
      .reset(reset),
      .ev_if(evt_if[g])
    );

    rrx_run_ctl u_run (
      .clock(clock),
      .reset(reset),
      .enable(state_reg.en[g]),
      .count_tick(count_tick[g]),
      .running(running[g])
    );
  end

  always_comb
  begin
    logic [CH_IDX_W-1:0] idx;
    logic clr;
    logic fire;
    logic ch_w;
    logic ch_r;
    idx = '0;
    clr = 1'b0;
    fire = 1'b0;
    ch_w = 1'b0;
    ch_r = 1'b0;
    state_next = state_reg;
    state_next.rdata = '0;
    state_next.run = running;
    idx = reg_addr[CH_IDX_W-1:0];
    if (reg_write && reg_addr == OFS_SEL)
      state_next.sel = reg_wdata[SEL_W-1:0];
    if (reg_read && reg_addr == OFS_SEL)
      state_next.rdata = DATA_W'(state_reg.sel);
    for (int i = 0; i < NUM_CH; i++)
    begin
      clr = reg_write && reg_addr == OFS_IC[i] && !reg_wdata[IC_IR_BIT];
      ch_w = reg_write && rrx_ch_hit(reg_addr, OFS_CH_BASE[i]);
      ch_r = reg_read && rrx_ch_hit(reg_addr, OFS_CH_BASE[i]);
      if (reg_write && reg_addr == OFS_IC[i])
        state_next.lvl[i] = reg_wdata[IC_LVL_W-1:0];
      if (reg_read && reg_addr == OFS_IC[i])
        state_next.rdata = DATA_W'({state_reg.pending[i], state_reg.lvl[i]});
      if (ch_w)
      begin
        case (idx)
          R_CON0:
          begin
            state_next.en[i] = reg_wdata[CON0_EN];
            state_next.cfg[i].header_required = reg_wdata[CON0_HDR];
            state_next.cfg[i].special_en = reg_wdata[CON0_SPEC];
            state_next.cfg[i].pattern = reg_wdata[CON0_PAT];
          end
          R_CON2: state_next.ovf_en[i] = reg_wdata[CON2_OVF_EN];
          R_INT: state_next.int_en[i] = reg_wdata[INT_W-1:0];
          R_HDMIN: state_next.cfg[i].hd_min = reg_wdata[HD_W-1:0];
          R_HDMAX: state_next.cfg[i].hd_max = reg_wdata[HD_W-1:0];
          R_D0MIN: state_next.cfg[i].d0_min = reg_wdata[DW_W-1:0];
          R_D0MAX: state_next.cfg[i].d0_max = reg_wdata[DW_W-1:0];
          R_D1MIN: state_next.cfg[i].d1_min = reg_wdata[DW_W-1:0];
          R_D1MAX: state_next.cfg[i].d1_max = reg_wdata[DW_W-1:0];
          R_CPC:
          begin
            state_next.cfg[i].compare_bit_count_select = reg_wdata[CPN_W-1:0];
            state_next.cfg[i].cmp_en = reg_wdata[CPC_EN];
          end
          R_CPD: state_next.cfg[i].cmp_data = reg_wdata[DW_W-1:0];
          default: ;
        endcase
      end
      if (ch_r)
      begin
        case (idx)
          R_CON0:
          begin
            state_next.rdata[CON0_EN] = state_reg.en[i];
            state_next.rdata[CON0_HDR] = state_reg.cfg[i].header_required;
            state_next.rdata[CON0_SPEC] = state_reg.cfg[i].special_en;
            state_next.rdata[CON0_PAT] = state_reg.cfg[i].pattern;
          end
          R_CON2:
          begin
            state_next.rdata[CON2_RUN] = running[i];
            state_next.rdata[CON2_OVF] = ovf_flag[i];
            state_next.rdata[CON2_OVF_EN] = state_reg.ovf_en[i];
          end
          R_INT: state_next.rdata = DATA_W'(state_reg.int_en[i]);
          R_HDMIN: state_next.rdata = DATA_W'(state_reg.cfg[i].hd_min);
          R_HDMAX: state_next.rdata = DATA_W'(state_reg.cfg[i].hd_max);
          R_D0MIN: state_next.rdata = DATA_W'(state_reg.cfg[i].d0_min);
          R_D0MAX: state_next.rdata = DATA_W'(state_reg.cfg[i].d0_max);
          R_D1MIN: state_next.rdata = DATA_W'(state_reg.cfg[i].d1_min);
          R_D1MAX: state_next.rdata = DATA_W'(state_reg.cfg[i].d1_max);
          R_CPC: state_next.rdata = DATA_W'({state_reg.cfg[i].cmp_en,
            state_reg.cfg[i].compare_bit_count_select});
          R_CPD: state_next.rdata = DATA_W'(state_reg.cfg[i].cmp_data);
          default: ;
        endcase
      end
      // gate each source by its enable; overflow enable sits in CON2
      fire = |(events[i] & {state_reg.ovf_en[i], state_reg.int_en[i]});
      // sticky: only a software write of 0 clears, and an event wins
      state_next.pending[i] = fire
        || (state_reg.pending[i] && !clr);
      state_next.irq[i] = state_next.pending[i]
        && state_next.sel[SEL_BIT[i]];
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign reg_rdata = state_reg.rdata;
  assign channel_enable = state_reg.en;
  assign running_flag = state_reg.run;
  assign irq_request = state_reg.irq;
endmodule : rrx_top
`default_nettype wire

// file: verif/rrx_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
module rrx_top_checker
  import rrx_pkg::*;
#(
  parameter int CHANNELS = rrx_pkg::NUM_CH
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [rrx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rrx_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [rrx_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [rrx_pkg::NUM_CH-1:0] count_tick,
  input wire logic [rrx_pkg::NUM_CH-1:0] channel_enable,
  input wire logic [rrx_pkg::NUM_CH-1:0] running_flag,
  input wire logic [rrx_pkg::NUM_CH-1:0] irq_request
);
  localparam logic [ADDR_W-1:0] A_CON0 = OFS_CH_BASE[0] | {7'h00, R_CON0};
  logic [1:0] tick_seen;
  // ticks seen since the enable bit showed up, saturating
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      tick_seen <= 2'h0;
    else if (!channel_enable[0] || running_flag[0])
      tick_seen <= 2'h0;
    else if (count_tick[0] && tick_seen != 2'h3)
      tick_seen <= tick_seen + 2'h1;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence s_second_tick;
    channel_enable[0] && !running_flag[0] && count_tick[0] && tick_seen == 2'h1;
  endsequence
  sequence s_stop_tick;
    !channel_enable[0] && running_flag[0] && count_tick[0];
  endsequence
  chk_rdata_idle: assert property (!reg_read |=> reg_rdata == '0)
    else $error("read data not zero outside read slot");
  chk_unmapped_zero: assert property
    (reg_read && reg_addr[11:8] == 4'h3 |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  chk_start_bound: assert property (s_second_tick |-> ##[1:3] running_flag[0])
    else $error("running flag late after start");
  chk_stop_bound: assert property (s_stop_tick |-> ##[1:3] !running_flag[0])
    else $error("running flag late after stop");
  chk_run_needs_en: assert property ($rose(running_flag[0]) |-> $past(channel_enable[0]))
    else $error("running flag rose without enable");
  chk_irq_sticky0: assert property (irq_request[0] && !(reg_write &&
    (reg_addr == OFS_IC[0] || reg_addr == OFS_SEL)) |=> irq_request[0])
    else $error("channel 0 request dropped by itself");
  chk_irq_sticky1: assert property (irq_request[1] && !(reg_write &&
    (reg_addr == OFS_IC[1] || reg_addr == OFS_SEL)) |=> irq_request[1])
    else $error("channel 1 request dropped by itself");
  chk_route_off0: assert property (reg_write && reg_addr == OFS_SEL &&
    !reg_wdata[SEL_BIT[0]] |=> !irq_request[0])
    else $error("channel 0 routed while deselected");
  chk_route_off1: assert property (reg_write && reg_addr == OFS_SEL &&
    !reg_wdata[SEL_BIT[1]] |=> !irq_request[1])
    else $error("channel 1 routed while deselected");
  chk_pend_read: assert property (reg_read && reg_addr == OFS_IC[0] &&
    irq_request[0] |=> reg_rdata[IC_IR_BIT])
    else $error("routed request without pending bit");
  chk_enable_echo: assert property (reg_write && reg_addr == A_CON0 |=>
    channel_enable[0] == $past(reg_wdata[CON0_EN]))
    else $error("enable output differs from written bit");
endmodule : rrx_top_checker
`default_nettype wire

// file: verif/rrx_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rrx_host_model
  import rrx_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] tick_div,
  input wire logic [NUM_CH-1:0] irq_request,
  output logic [NUM_CH-1:0] count_tick,
  output logic [7:0] accepts
);
  logic [3:0] div_cnt;
  logic [NUM_CH-1:0] irq_seen;
  // channel 1 ticks at mid-count, channel 0 at the count's end; the two align only when tick_div is 1 or 2
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      div_cnt <= 4'h0;
      count_tick <= '0;
      irq_seen <= '0;
      accepts <= 8'h00;
    end
    else
    begin
      div_cnt <= (div_cnt >= tick_div - 4'h1) ? 4'h0 : div_cnt + 4'h1;
      count_tick[0] <= (div_cnt == tick_div - 4'h1);
      count_tick[1] <= (div_cnt == (tick_div >> 1));
      irq_seen <= irq_request;
      // acceptance only counts; the flag is left for software
      if ((irq_request & ~irq_seen) != '0)
        accepts <= accepts + 8'h01;
    end
  end
endmodule : rrx_host_model
`default_nettype wire

// file: verif/test_rrx_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_rrx_top;
  import rrx_pkg::*;
  logic clock, reset, reg_write, reg_read, rd_pend;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, lvl;
  logic [NUM_CH-1:0] count_tick, measure_end, channel_enable;
  logic [NUM_CH-1:0] running_flag, irq_request;
  logic [CNT_W-1:0] meas0, meas1, cnt0, cnt1;
  logic [BIT_CNT_W-1:0] bit_count;
  logic [DW_W-1:0] rx_data;
  logic [3:0] tick_div;
  logic [7:0] accepts;
  logic [DATA_W-1:0] exp_q [$];
  logic [CNT_W-1:0] ev_val [6];
  logic [DATA_W-1:0] win [6] = '{16'h0064, 16'h00C8, 16'h000A, 16'h0014,
    16'h001E, 16'h0028};
  int ev_bit [6] = '{EV_HDR, EV_DATA, EV_DATA, EV_SPEC, EV_ERR, EV_MEAS};
  int num_errors, num_checks;
  int unsigned seed;
  rrx_top #(.CHANNELS(NUM_CH)) i_rrx_top (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .count_tick(count_tick),
    .measure_end(measure_end), .measured_value0(meas0),
    .measured_value1(meas1), .running_counter0(cnt0),
    .running_counter1(cnt1), .received_bit_count(bit_count),
    .first_receive_data(rx_data), .channel_enable(channel_enable),
    .running_flag(running_flag), .irq_request(irq_request));
  rrx_host_model i_rrx_host_model (.clock(clock), .reset(reset),
    .tick_div(tick_div), .irq_request(irq_request),
    .count_tick(count_tick), .accepts(accepts));
  function automatic logic [ADDR_W-1:0] ra(input int ch,
                                           input logic [CH_IDX_W-1:0] r);
    ra = OFS_CH_BASE[ch] | {7'h00, r};
  endfunction : ra
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
    num_checks++;
    if (got !== e)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask : chk
  // one idle cycle after each strobe keeps a strobe from being set twice
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
  endtask : rd
  task automatic pulse(input int ch);
    measure_end[ch] <= 1'b1;
    @(posedge clock);
    measure_end[ch] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : pulse
  task automatic ir_set(input int ch);
    rd(OFS_IC[ch], lvl | 16'h0008);
    wr(OFS_IC[ch], lvl);
    rd(OFS_IC[ch], lvl);
  endtask : ir_set
  task automatic wait_run(input int ch, input logic v, input int lim);
    int n;
    n = 0;
    while (running_flag[ch] !== v && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    num_checks++;
    if (running_flag[ch] !== v)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, running_flag[ch], v);
      give_verdict();
    end
  endtask : wait_run
  always @(posedge clock)
  begin
    rd_pend <= reg_read;
    if (rd_pend === 1'b1)
      chk(reg_rdata, exp_q.pop_front());
  end
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial
  begin
    reset = 1'b1;
    {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {measure_end, meas0, cnt0, cnt1, bit_count, rx_data} = '0;
    tick_div = 4'h4;
    num_errors = 0;
    num_checks = 0;
    seed = $urandom(32'h5FC270AD);
    lvl = DATA_W'($urandom % 8);
    meas1 = CNT_W'($urandom);
    ev_val = '{16'h0096, 16'h000A + CNT_W'($urandom % 11), 16'h0023,
      16'h0096, 16'h003C, 16'h01F4};
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(OFS_IC[0], 16'h0000);
    rd(OFS_IC[1], 16'h0000);
    rd(OFS_SEL, 16'h0000);
    rd(12'h300, 16'h0000);
    wr(OFS_IC[0], lvl | 16'h0008);
    rd(OFS_IC[0], lvl);
    for (int k = 0; k < 6; k++)
      wr(ra(0, R_HDMIN + 5'(k)), win[k]);
    wr(ra(0, R_CPC), 16'h000B);
    wr(ra(0, R_CPD), 16'h00A5);
    wr(ra(0, R_CON0), 16'h000F);
    chk(16'(channel_enable), 16'h0001);
    wait_run(0, 1'b1, 2 * 4 + 3);
    rd(ra(0, R_CON2), 16'h0001);
    for (int k = 0; k < 6; k++)
    begin
      wr(ra(0, R_INT), 16'h0001 << ev_bit[k]);
      meas0 <= ev_val[k];
      pulse(0);
      ir_set(0);
    end
    meas0 <= 16'h003C;
    wr(ra(0, R_INT), 16'h0001 << EV_HDR);
    pulse(0);
    rd(OFS_IC[0], lvl);
    wr(ra(0, R_INT), 16'h0001 << EV_DONE);
    cnt0 <= 16'h012C;
    repeat (3) @(posedge clock);
    ir_set(0);
    wr(ra(0, R_INT), 16'h0001 << EV_BFUL);
    bit_count <= 6'h2F;
    repeat (3) @(posedge clock);
    rd(OFS_IC[0], lvl);
    bit_count <= 6'h30;
    repeat (3) @(posedge clock);
    ir_set(0);
    wr(ra(0, R_INT), 16'h0001 << EV_CMP);
    // low nibble matches only; compare width is four bits here
    rx_data <= 8'h35;
    repeat (3) @(posedge clock);
    ir_set(0);
    wr(ra(0, R_INT), 16'h00FF);
    meas0 <= 16'h0096;
    pulse(0);
    chk(16'(irq_request), 16'h0000);
    wr(OFS_SEL, 16'h0010);
    chk(16'(irq_request), 16'h0001);
    pulse(0);
    chk(16'(irq_request), 16'h0001);
    chk(16'(accepts), 16'h0001);
    measure_end[0] <= 1'b1;
    @(posedge clock);
    measure_end[0] <= 1'b0;
    // clear strobe lands on the edge where the registered event sets pending
    wr(OFS_IC[0], lvl);
    rd(OFS_IC[0], lvl | 16'h0008);
    wr(OFS_SEL, 16'h0000);
    chk(16'(irq_request), 16'h0000);
    rd(OFS_IC[0], lvl | 16'h0008);
    wr(OFS_IC[0], lvl);
    wr(ra(0, R_INT), 16'h0000);
    wr(ra(0, R_CON0), 16'h0001);
    wr(ra(0, R_CON2), 16'h0004);
    cnt0 <= 16'hFFFF;
    @(posedge clock);
    cnt0 <= 16'h0000;
    repeat (3) @(posedge clock);
    ir_set(0);
    rd(ra(0, R_CON2), 16'h0007);
    pulse(0);
    rd(ra(0, R_CON2), 16'h0005);
    tick_div <= 4'h7;
    wr(ra(1, R_INT), 16'h0001 << EV_MEAS);
    wr(ra(1, R_CON0), 16'h0001);
    wait_run(1, 1'b1, 2 * 7 + 3);
    wr(OFS_SEL, 16'h0020);
    pulse(1);
    chk(16'(irq_request), 16'h0002);
    rd(OFS_IC[1], 16'h0008);
    rd(OFS_IC[0], lvl);
    wr(ra(0, R_CON0), 16'h0000);
    wait_run(0, 1'b0, 7 + 3);
    wr(ra(1, R_CON0), 16'h0000);
    wait_run(1, 1'b0, 7 + 3);
    chk(16'(channel_enable), 16'h0000);
    repeat (4) @(posedge clock);
    give_verdict();
  end
endmodule : test_rrx_top
bind rrx_top rrx_top_checker #(.CHANNELS(CHANNELS)) i_rrx_top_checker (
  .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .count_tick(count_tick), .channel_enable(channel_enable),
  .running_flag(running_flag), .irq_request(irq_request));
`default_nettype wire
